/* File: design/oe_encoder.v */
// Functional notes
// - xy select sits in word bits 3..0, seven sources
// - concatenated operand puts a on top, b below
// - accumulator-plus-c xy choice adds c to output register
// - z select sits in bits 6..4, six sources
// - shifted z sources move arithmetically down seventeen bits
// - carry source field sits in bits 14..12
// - external carry choice feeds carry port into bit 11
// - four rounding choices for cascade or output, infinity or zero
// - seven presets, or custom word from individual fields
`timescale 1ns/1ns
`default_nettype none
module oe_encoder (
    // clock and reset
    input wire CLK,
    input wire RST,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // external carry
    input wire CARRY_IN,
    // instruction to slice
    output reg [14:0] OPCODE,
    output reg OPCODE_VALID
);
    `include "oe_regs.vh"
    reg [31:0] ctrl_reg;
    reg [31:0] custom_reg;
    reg [14:0] word_next;
    reg [31:0] rd_next;
    reg err_next;
    reg [1:0] settle_reg;
    wire [14:0] preset_word;
    wire custom_on;
    wire [3:0] xy_sel;
    wire [2:0] z_sel;
    wire [2:0] cy_sel;
    wire acc;
    wire legal;
    assign acc = PSEL & PENABLE & ~PREADY;
    assign custom_on = ctrl_reg[`OE_CTRL_CUSTOM_BIT];
    assign xy_sel = custom_reg[`OE_XY_MSB:`OE_XY_LSB];
    assign z_sel = custom_reg[`OE_Z_MSB:`OE_Z_LSB];
    assign cy_sel = custom_reg[`OE_CY_MSB:`OE_CY_LSB];
    assign legal = (xy_sel <= `OE_XY_CATC) && (z_sel <= `OE_Z_OUT17);

    oe_preset_rom u_rom (
        .CLK(CLK),
        .sel(ctrl_reg[2:0]),
        .word(preset_word)
    );

    always @*
    begin
        if (custom_on)
        begin
            // cat code puts a over b
            // code five selects output plus c
            // codes four and five shifted z
            word_next = custom_reg[14:0];
            word_next[`OE_CY_MSB:`OE_CY_LSB] = cy_sel;
            word_next[`OE_CIN_BIT] = (cy_sel == `OE_CY_EXT) ? CARRY_IN : 1'b0;
        end
        else
        begin
            word_next = preset_word;
        end
    end

    // register reads
    always @*
    begin
        rd_next = 32'h0000_0000;
        err_next = 1'b0;
        if (PADDR == `OE_CTRL_ADDR)
            rd_next = {28'h000_0000, ctrl_reg[3:0]};
        else if (PADDR == `OE_CUSTOM_ADDR)
            rd_next = {17'h0_0000, custom_reg[14:0]};
        else if (PADDR == `OE_WORD_ADDR)
            rd_next = {17'h0_0000, OPCODE};
        else if (PADDR == `OE_STATUS_ADDR)
            rd_next = {30'h0000_0000, legal, OPCODE_VALID};
        else
            err_next = 1'b1;
    end

    // apb access
    always @(posedge CLK)
    begin
        if (RST)
        begin
            ctrl_reg <= `OE_CTRL_RST;
            custom_reg <= `OE_CUSTOM_RST;
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= acc;
            PSLVERR <= acc & err_next;
            if (acc & ~PWRITE)
                PRDATA <= rd_next;
            if (acc & PWRITE & (PADDR == `OE_CTRL_ADDR))
                ctrl_reg <= {28'h000_0000, PWDATA[3:0]};
            if (acc & PWRITE & (PADDR == `OE_CUSTOM_ADDR))
                custom_reg <= {17'h0_0000, PWDATA[14:0]};
        end
    end

    always @(posedge CLK)
    begin
        if (RST)
        begin
            OPCODE <= 15'h0000;
            OPCODE_VALID <= 1'b0;
            settle_reg <= 2'b00;
        end
        else
        begin
            OPCODE <= word_next;
            if (acc & PWRITE)
                settle_reg <= 2'b00;
            else if (settle_reg != 2'b11)
                settle_reg <= settle_reg + 2'b01;
            OPCODE_VALID <= (settle_reg == 2'b11);
        end
    end
endmodule // oe_encoder
`default_nettype wire

/* File: design/oe_regs.vh */
`ifndef OE_REGS_VH
`define OE_REGS_VH
// apb register offsets
`define OE_CTRL_ADDR 12'h000
`define OE_CUSTOM_ADDR 12'h004
`define OE_WORD_ADDR 12'h008
`define OE_STATUS_ADDR 12'h00C
// control fields
`define OE_CTRL_PRESET_LSB 0
`define OE_CTRL_PRESET_W 3
`define OE_CTRL_CUSTOM_BIT 3
// custom fields
`define OE_XY_LSB 0
`define OE_XY_MSB 3
`define OE_Z_LSB 4
`define OE_Z_MSB 6
`define OE_ALU_LSB 7
`define OE_ALU_MSB 10
`define OE_CIN_BIT 11
`define OE_CY_LSB 12
`define OE_CY_MSB 14
`define OE_WORD_W 15
// xy sources
`define OE_XY_ZERO 4'h0
`define OE_XY_OUT 4'h1
`define OE_XY_CAT 4'h2
`define OE_XY_PROD 4'h3
`define OE_XY_C 4'h4
`define OE_XY_OUTC 4'h5
`define OE_XY_CATC 4'h6
// z sources
`define OE_Z_ZERO 3'h0
`define OE_Z_CASC 3'h1
`define OE_Z_OUT 3'h2
`define OE_Z_C 3'h3
`define OE_Z_CASC17 3'h4
`define OE_Z_OUT17 3'h5
`define OE_SHIFT 17
// alu modes
`define OE_ALU_ADD 4'h0
`define OE_ALU_SUB 4'h3
// carry sources
`define OE_CY_ZERO 3'h0
`define OE_CY_ONE 3'h1
`define OE_CY_EXT 3'h2
`define OE_CY_RCASC_INF 3'h3
`define OE_CY_RCASC_ZERO 3'h4
`define OE_CY_ROUT_INF 3'h5
`define OE_CY_ROUT_ZERO 3'h6
`define OE_CY_WIDE 3'h7
// presets
`define OE_PR_C_PROD 3'h0
`define OE_PR_CASC_PROD 3'h1
`define OE_PR_ACC_PROD 3'h2
`define OE_PR_PROD 3'h3
`define OE_PR_C_CAT 3'h4
`define OE_PR_C_MCAT 3'h5
`define OE_PR_C 3'h6
// reset values
`define OE_CTRL_RST 32'h0000_0000
`define OE_CUSTOM_RST 32'h0000_0000
`endif

/* File: design/oe_preset_rom.v */
`timescale 1ns/1ns
`default_nettype none
module oe_preset_rom (
    // clock
    input wire CLK,
    // lookup
    input wire [2:0] sel,
    output reg [14:0] word
);
    `include "oe_regs.vh"
    // preset word lookup
    always @(posedge CLK)
    begin
        case (sel)
            `OE_PR_C_PROD: word <= {3'h0, 1'b0, `OE_ALU_ADD, `OE_Z_C, `OE_XY_PROD};
            `OE_PR_CASC_PROD: word <= {3'h0, 1'b0, `OE_ALU_ADD, `OE_Z_CASC, `OE_XY_PROD};
            `OE_PR_ACC_PROD: word <= {3'h0, 1'b0, `OE_ALU_ADD, `OE_Z_OUT, `OE_XY_PROD};
            `OE_PR_PROD: word <= {3'h0, 1'b0, `OE_ALU_ADD, `OE_Z_ZERO, `OE_XY_PROD};
            `OE_PR_C_CAT: word <= {3'h0, 1'b0, `OE_ALU_ADD, `OE_Z_C, `OE_XY_CAT};
            `OE_PR_C_MCAT: word <= {3'h0, 1'b0, `OE_ALU_SUB, `OE_Z_C, `OE_XY_CAT};
            default: word <= {3'h0, 1'b0, `OE_ALU_ADD, `OE_Z_C, `OE_XY_ZERO};
        endcase
    end
endmodule // oe_preset_rom
`default_nettype wire

/* File: dv/oe_slice_model.sv */
`timescale 1ns/1ns
`default_nettype none
module oe_slice_model(
    // instruction in
    input wire logic [14:0] OPCODE,
    // decoded fields
    output logic [3:0] xy,
    output logic [2:0] z,
    output logic [2:0] cy
);
assign xy = OPCODE[3:0];
assign z = OPCODE[6:4];
assign cy = OPCODE[14:12];
endmodule // oe_slice_model
`default_nettype wire

/* File: dv/oe_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "oe_regs.vh"
module oe_props(
    input wire logic CLK,RST,PSEL,PENABLE,PWRITE,PREADY,PSLVERR,CARRY_IN,
    input wire logic [31:0] PRDATA,
    input wire logic [14:0] OPCODE
);
wire wr = PREADY && PWRITE;
default clocking @(posedge CLK); endclocking
default disable iff (RST);
a_rdy_wait: assert property(PSEL&&PENABLE&&!PREADY|=>PREADY)else $error("ready late");
a_rdy_pulse: assert property(PREADY|=>!PREADY)else $error("ready long");
a_rdy_cause: assert property(PREADY|->$past(PSEL&&PENABLE))else $error("ready idle");
a_err_rdy: assert property(PSLVERR|->PREADY)else $error("err alone");
a_err_rdata: assert property(PSLVERR&&!PWRITE|->PRDATA==0)else $error("err data");
a_cin_bit: assert property(OPCODE[14:12]==`OE_CY_EXT&&$stable(OPCODE[14:12])
    |->OPCODE[11]==$past(CARRY_IN))else $error("carry bit");
a_cin_zero: assert property(OPCODE[14:12]!=`OE_CY_EXT|->!OPCODE[11])else $error("bit 11");
a_word_hold: assert property($changed(OPCODE&15'h77FF)|->$past(wr)||$past(wr,2)
    ||$past(wr,3)||$past(RST)||$past(RST,2)||$past(RST,3))else $error("word moved");
endmodule // oe_props
bind oe_encoder oe_props u_props(.CLK,.RST,.PSEL,.PENABLE,.PWRITE,.PREADY,.PSLVERR,
    .CARRY_IN,.PRDATA,.OPCODE);
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "oe_regs.vh"
module tb_top;
logic CLK=0,RST=1,PSEL=0,PENABLE=0,PWRITE=0,CARRY_IN=0,PREADY,PSLVERR,OPCODE_VALID,er;
logic [11:0] PADDR=0;
logic [31:0] PWDATA=0,PRDATA,rd;
logic [14:0] OPCODE,w;
logic [3:0] m_xy;
logic [2:0] m_z,m_cy;
int n_mismatch=0,samples_checked=0,i,n;
logic [14:0] pw[7]='{15'h0033,15'h0013,15'h0023,15'h0003,15'h0032,15'h01B2,15'h0030};
always #5 CLK=~CLK;
oe_encoder u_dut(.CLK,.RST,.PSEL,.PENABLE,.PWRITE,.PADDR,.PWDATA,.PRDATA,.PREADY,
    .PSLVERR,.CARRY_IN,.OPCODE,.OPCODE_VALID);
oe_slice_model u_sm(.OPCODE,.xy(m_xy),.z(m_z),.cy(m_cy));
task give_verdict;
    $display("checked %0d mismatches %0d",samples_checked,n_mismatch);
    if(n_mismatch==0&&samples_checked>0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
task chk(input logic [31:0] g,e);
    samples_checked++;
    if(g!==e)
    begin
        n_mismatch++;
        $display("[ERR] t=%0t got %h exp %h",$time,g,e);
    end
endtask
task apb(input logic wr,input logic [11:0] a,input logic [31:0] d);
    PSEL<=1;
    PWRITE<=wr;
    PADDR<=a;
    PWDATA<=d;
    @(posedge CLK) PENABLE<=1;
    n=0;
    do @(posedge CLK); while(PREADY!==1&&++n<20);
    if(n>=20)
    begin
        n_mismatch++;
        give_verdict;
    end
    rd=PRDATA;
    er=PSLVERR;
    PSEL<=0;
    PENABLE<=0;
    @(posedge CLK);
endtask
initial
begin
    repeat(10) @(posedge CLK);
    RST<=0;
    @(posedge CLK);
    apb(0,`OE_CTRL_ADDR,0); chk(rd,`OE_CTRL_RST);
    apb(0,`OE_CUSTOM_ADDR,0); chk(rd,`OE_CUSTOM_RST);
    apb(1,12'h010,1); chk({rd[30:0],er},1);
    $display("reset and refusal done");
    for(i=0;i<7;i++)
    begin
        apb(1,`OE_CTRL_ADDR,i);
        repeat(3) @(posedge CLK);
        chk(OPCODE,pw[i]);
    end
    $display("presets done");
    CARRY_IN<=1;
    apb(1,`OE_CTRL_ADDR,8);
    for(i=0;i<8;i++)
    begin
        w={i[2:0],i==2,i[0]?`OE_ALU_SUB:`OE_ALU_ADD,3'(i%6),4'(i%7)};
        apb(1,`OE_CUSTOM_ADDR,w);
        repeat(2) @(posedge CLK);
        chk({m_cy,OPCODE[11:7],m_z,m_xy},w);
        apb(0,`OE_WORD_ADDR,0); chk(rd,w);
    end
    apb(1,`OE_CUSTOM_ADDR,15'h2000);
    CARRY_IN<=0;
    repeat(2) @(posedge CLK);
    chk(OPCODE,15'h2000);
    CARRY_IN<=1;
    repeat(2) @(posedge CLK);
    chk(OPCODE,15'h2800);
    chk(OPCODE_VALID,1);
    apb(0,`OE_STATUS_ADDR,0); chk(rd,3);
    apb(1,`OE_CUSTOM_ADDR,15'h0007); chk(OPCODE_VALID,0);
    repeat(4) @(posedge CLK);
    apb(0,`OE_STATUS_ADDR,0); chk(rd,1);
    apb(0,12'h010,0); chk({rd[30:0],er},1);
    $display("custom done");
    give_verdict;
end
endmodule // tb_top
`default_nettype wire
